//--- shared/interrupt_defines.svh
/*
  offsets, field positions, reset values, jump addresses and function codes
  of the interrupt vectoring block. assumes inclusion by bare name.
*/
`ifndef INTERRUPT_DEFINES_SVH
`define INTERRUPT_DEFINES_SVH

`define OFF_CTRL 8'h00
`define OFF_CMP 8'h04
`define OFF_STATUS 8'h08
`define OFF_EIMON 8'h0c
`define OFF_BUFMON 8'h10
`define OFF_INMON 8'h14
`define CTRL_RECOV_BIT 0
`define CTRL_RESET 1'h0
`define CMP_RESET 18'h00000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define VEC_FAULT 15'h0000
`define VEC_FAULT_RECOV 15'h0140
`define VEC_RESUME 15'h0009
`define VEC_CMP 15'h000a
`define VEC_OVF 15'h000b
`define VEC_SYNC 15'h000e
`define VEC_EI 15'h0040
`define VEC_FN 15'h0050
`define VEC_OUT 15'h0060
`define VEC_IN 15'h0070
`define VEC_HIGH_CHAN 15'h0080

`define OP_GROUP 6'h28
`define SUB_CMP_ARM 6'h0c
`define SUB_REL_ALL 6'h18
`define SUB_REL_OUT 6'h1a
`define SUB_SET_ALL 6'h1c
`define SUB_SET_OUT 6'h1e
`define OP_BAD0 6'h00
`define OP_BAD1 6'h01
`define OP_BAD77 6'h3f
`define RTC_ALL_ONES 18'h3ffff

`endif

//--- shared/interrupt_pkg.sv
/*
  types of the interrupt vectoring block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package interrupt_pkg;
  typedef enum logic [3:0] {
    SRC_NONE, SRC_FAULT, SRC_RESUME, SRC_CMP, SRC_OVF, SRC_SYNC,
    SRC_EI, SRC_FN, SRC_OUT, SRC_IN
  } src_kind_t;
  typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} seq_state_t;
endpackage

//--- shared/pick_if.sv
/*
  pending interrupt set toward the priority picker and its choice back.
  assumes the picker is purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
interface pick_if;
  import interrupt_pkg::*;
  logic fault, resume, cmp, ovf, sync, alt, recov;
  logic [15:0] ei, fn, out, in;
  src_kind_t kind;
  logic [3:0] chan;
  logic [14:0] addr;
  modport core (output fault, resume, cmp, ovf, sync, alt, recov, ei, fn, out, in,
                input kind, chan, addr);
  modport picker (input fault, resume, cmp, ovf, sync, alt, recov, ei, fn, out, in,
                  output kind, chan, addr);
endinterface
`default_nettype wire

//--- core/rtc_event_check.sv
/*
  detects clock compare and clock overflow at a clock update.
  assumes update is a one-cycle strobe with old and new counts stable.
*/
`timescale 1ns/10ps
`default_nettype none
`include "interrupt_defines.svh"
module rtc_event_check (
  input wire logic rtcUpdate,
  input wire logic [17:0] countOld,
  input wire logic [17:0] countNew,
  input wire logic [17:0] compareConst,
  input wire logic armed,
  output logic cmpHit,
  output logic ovfHit
);
  assign cmpHit = rtcUpdate && armed && (countNew == compareConst);
  assign ovfHit = rtcUpdate && (countOld == `RTC_ALL_ONES);
endmodule
`default_nettype wire

//--- core/priority_picker.sv
/*
  picks the highest pending interrupt and forms its jump address.
  assumes ei pending is already gated by the external lockout.
*/
`timescale 1ns/10ps
`default_nettype none
`include "interrupt_defines.svh"
module priority_picker
  import interrupt_pkg::*;
(
  pick_if.picker pk
);
  // bit 4 set when any channel pends, low bits give the lowest channel
  function automatic logic [4:0] lowest_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [14:0] mon_addr(input logic [14:0] base, input logic [3:0] ch);
    return base + {11'h000, ch[2:0], 1'b0} + (ch[3] ? `VEC_HIGH_CHAN : 15'h0000);
  endfunction

  logic [4:0] eiSel, fnSel, outSel, inSel, firstSel, secondSel;
  src_kind_t firstKind, secondKind;
  logic [14:0] firstBase, secondBase;

  assign eiSel = lowest_set(pk.ei);
  assign fnSel = lowest_set(pk.fn);
  assign outSel = lowest_set(pk.out);
  assign inSel = lowest_set(pk.in);
  assign firstSel = pk.alt ? inSel : outSel;
  assign secondSel = pk.alt ? outSel : inSel;
  assign firstKind = pk.alt ? SRC_IN : SRC_OUT;
  assign secondKind = pk.alt ? SRC_OUT : SRC_IN;
  assign firstBase = pk.alt ? `VEC_IN : `VEC_OUT;
  assign secondBase = pk.alt ? `VEC_OUT : `VEC_IN;

  always_comb begin
    pk.kind = SRC_NONE;
    pk.chan = 4'h0;
    pk.addr = `VEC_FAULT;
    // specials first in fixed order, then ei, fn, and out and in swapped by alt
    if (pk.fault) begin
      pk.kind = SRC_FAULT;
      pk.addr = pk.recov ? `VEC_FAULT_RECOV : `VEC_FAULT;
    end else if (pk.resume) begin
      pk.kind = SRC_RESUME;
      pk.addr = `VEC_RESUME;
    end else if (pk.cmp) begin
      pk.kind = SRC_CMP;
      pk.addr = `VEC_CMP;
    end else if (pk.ovf) begin
      pk.kind = SRC_OVF;
      pk.addr = `VEC_OVF;
    end else if (pk.sync) begin
      pk.kind = SRC_SYNC;
      pk.addr = `VEC_SYNC;
    end else if (eiSel[4]) begin
      pk.kind = SRC_EI;
      pk.chan = eiSel[3:0];
      pk.addr = mon_addr(`VEC_EI, eiSel[3:0]);
    end else if (fnSel[4]) begin
      pk.kind = SRC_FN;
      pk.chan = fnSel[3:0];
      pk.addr = mon_addr(`VEC_FN, fnSel[3:0]);
    end else if (firstSel[4]) begin
      pk.kind = firstKind;
      pk.chan = firstSel[3:0];
      pk.addr = mon_addr(firstBase, firstSel[3:0]);
    end else if (secondSel[4]) begin
      pk.kind = secondKind;
      pk.chan = secondSel[3:0];
      pk.addr = mon_addr(secondBase, secondSel[3:0]);
    end
  end
endmodule
`default_nettype wire

//--- core/interrupt_vectoring.sv
/*
  special and channel monitor interrupts: generation, lockout, priority,
  honoring and jump address delivery, with an AXI4-Lite register slave.
  assumes all inputs synchronous to clk_sys; the processor strobes
  fetchStart when a fetch sequence is next and instrDone when the
  instruction taken at the interrupt address has completed.
*/
`timescale 1ns/10ps
`default_nettype none
`include "interrupt_defines.svh"
module interrupt_vectoring
  import interrupt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic opValid,
  input wire logic [5:0] opMajor,
  input wire logic [5:0] opMinor,
  input wire logic rtcUpdate,
  input wire logic [17:0] rtcCountOld,
  input wire logic [17:0] rtcCountNew,
  input wire logic resumeFault,
  input wire logic extSync,
  input wire logic [15:0] extRequest,
  input wire logic [15:0] monitorRequested,
  input wire logic [15:0] fnBufTerm,
  input wire logic [15:0] outBufTerm,
  input wire logic [15:0] inBufTerm,
  input wire logic fetchStart,
  input wire logic instrDone,
  output logic [15:0] extRequestAccept,
  output logic jumpValid,
  output logic [14:0] jumpAddr,
  output logic pcTransferBlock,
  output logic operandRestrict,
  output logic allLockout,
  output logic extLockout
);
  logic awHeld, wHeld;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic recovReg;
  logic [17:0] compareReg;
  logic cmpArmed, faultFlag, resumeFlag, cmpFlag, ovfFlag, syncFlag, altReg;
  logic [15:0] eiMon, fnMon, outMon, inMon;
  logic lastEiValid;
  logic [3:0] lastEiChan;
  seq_state_t seqReg, seq_next;
  logic cmpHit, ovfHit, honor, doWrite, relAll, setAll, relOut, setOut, armCmp, badOp;
  logic [15:0] accept, honorClr, eiRelease;
  logic [31:0] cmpMerged;
  pick_if pk ();

  function automatic logic is_mapped(input logic [7:0] a);
    return a == `OFF_CTRL || a == `OFF_CMP || a == `OFF_STATUS ||
           a == `OFF_EIMON || a == `OFF_BUFMON || a == `OFF_INMON;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  rtc_event_check rtcCheck (
    .rtcUpdate(rtcUpdate),
    .countOld(rtcCountOld),
    .countNew(rtcCountNew),
    .compareConst(compareReg),
    .armed(cmpArmed),
    .cmpHit(cmpHit),
    .ovfHit(ovfHit)
  );

  priority_picker picker (
    .pk(pk)
  );

  assign pk.fault = faultFlag;
  assign pk.resume = resumeFlag;
  assign pk.cmp = cmpFlag;
  assign pk.ovf = ovfFlag;
  assign pk.sync = syncFlag;
  assign pk.alt = altReg;
  assign pk.recov = recovReg;
  assign pk.ei = eiMon & ~{16{extLockout}};
  assign pk.fn = fnMon;
  assign pk.out = outMon;
  assign pk.in = inMon;

  // instruction decode
  assign relAll = opValid && opMajor == `OP_GROUP && opMinor == `SUB_REL_ALL;
  assign setAll = opValid && opMajor == `OP_GROUP && opMinor == `SUB_SET_ALL;
  assign relOut = opValid && opMajor == `OP_GROUP && opMinor == `SUB_REL_OUT;
  assign setOut = opValid && opMajor == `OP_GROUP && opMinor == `SUB_SET_OUT;
  assign armCmp = opValid && opMajor == `OP_GROUP && opMinor == `SUB_CMP_ARM;
  assign badOp = opValid && (opMajor == `OP_BAD0 || opMajor == `OP_BAD1 ||
                             opMajor == `OP_BAD77);

  // fault proceeds despite the lockout, everything else waits for the lockout
  assign honor = fetchStart && seqReg == SEQ_IDLE && pk.kind != SRC_NONE &&
                 (pk.kind == SRC_FAULT || !allLockout);
  assign honorClr = honor ? (16'h0001 << pk.chan) : 16'h0000;
  assign accept = extRequest & ~eiMon & ~{16{extLockout}};
  assign eiRelease = (relAll && lastEiValid) ? (16'h0001 << lastEiChan) : 16'h0000;
  assign doWrite = awHeld && wHeld && !bvalid;
  assign cmpMerged = merge({14'h0000, compareReg}, wrData, wrStrb);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 32'h00000000;
      wrStrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (clkEn) begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        awHeld <= 1'b1;
        wrAddr <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wHeld <= 1'b1;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= is_mapped(wrAddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      recovReg <= `CTRL_RESET;
      compareReg <= `CMP_RESET;
    end else if (clkEn && doWrite) begin
      if (wrAddr == `OFF_CTRL && wrStrb[0]) begin
        recovReg <= wrData[`CTRL_RECOV_BIT];
      end
      if (wrAddr == `OFF_CMP) begin
        compareReg <= cmpMerged[17:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (clkEn) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (araddr)
          `OFF_CTRL: rdata <= {31'h00000000, recovReg};
          `OFF_CMP: rdata <= {14'h0000, compareReg};
          `OFF_STATUS: rdata <= {19'h00000, syncFlag, ovfFlag, cmpFlag, resumeFlag, faultFlag,
                                 3'h0, seqReg == SEQ_RUN, altReg, cmpArmed, extLockout,
                                 allLockout};
          `OFF_EIMON: rdata <= {16'h0000, eiMon};
          `OFF_BUFMON: rdata <= {outMon, fnMon};
          `OFF_INMON: rdata <= {16'h0000, inMon};
          default: rdata <= 32'h00000000;
        endcase
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // special flags: a new event wins over the honoring clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      faultFlag <= 1'b0;
      resumeFlag <= 1'b0;
      cmpFlag <= 1'b0;
      ovfFlag <= 1'b0;
      syncFlag <= 1'b0;
      cmpArmed <= 1'b0;
    end else if (clkEn) begin
      faultFlag <= badOp || (faultFlag && !(honor && pk.kind == SRC_FAULT));
      resumeFlag <= resumeFault || (resumeFlag && !(honor && pk.kind == SRC_RESUME));
      cmpFlag <= cmpHit || (cmpFlag && !(honor && pk.kind == SRC_CMP));
      ovfFlag <= ovfHit || (ovfFlag && !(honor && pk.kind == SRC_OVF));
      syncFlag <= extSync || (syncFlag && !(honor && pk.kind == SRC_SYNC));
      cmpArmed <= armCmp || (cmpArmed && !cmpHit);
    end
  end

  // channel monitor flags
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      eiMon <= 16'h0000;
      fnMon <= 16'h0000;
      outMon <= 16'h0000;
      inMon <= 16'h0000;
      extRequestAccept <= 16'h0000;
    end else if (clkEn) begin
      eiMon <= (eiMon & ~eiRelease) | accept;
      extRequestAccept <= accept;
      fnMon <= (fnMon & ~(pk.kind == SRC_FN ? honorClr : 16'h0000)) |
               (fnBufTerm & monitorRequested);
      outMon <= (outMon & ~(pk.kind == SRC_OUT ? honorClr : 16'h0000)) |
                (outBufTerm & monitorRequested);
      inMon <= (inMon & ~(pk.kind == SRC_IN ? honorClr : 16'h0000)) |
               (inBufTerm & monitorRequested);
    end
  end

  // lockouts and the record of the last honored external request monitor
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      allLockout <= 1'b0;
      extLockout <= 1'b0;
      lastEiValid <= 1'b0;
      lastEiChan <= 4'h0;
      altReg <= 1'b0;
    end else if (clkEn) begin
      if (honor) begin
        allLockout <= 1'b1;
      end else if (relAll) begin
        allLockout <= 1'b0;
      end else if (setAll) begin
        allLockout <= 1'b1;
      end
      if (relOut) begin
        extLockout <= 1'b0;
      end else if (setOut) begin
        extLockout <= 1'b1;
      end
      if (honor) begin
        lastEiValid <= pk.kind == SRC_EI;
        lastEiChan <= pk.chan;
      end else if (relAll) begin
        lastEiValid <= 1'b0;
      end
      if (honor && (pk.kind == SRC_OUT || pk.kind == SRC_IN)) begin
        altReg <= !altReg;
      end
    end
  end

  always_comb begin
    seq_next = seqReg;
    case (seqReg)
      SEQ_IDLE: begin
        if (honor) begin
          seq_next = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (instrDone) begin
          seq_next = SEQ_IDLE;
        end
      end
      default: seq_next = SEQ_IDLE;
    endcase
  end

  // jump delivery; program counter is left untouched so a non-jump returns
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seqReg <= SEQ_IDLE;
      jumpValid <= 1'b0;
      jumpAddr <= `VEC_FAULT;
      pcTransferBlock <= 1'b0;
      operandRestrict <= 1'b0;
    end else if (clkEn) begin
      seqReg <= seq_next;
      jumpValid <= honor;
      pcTransferBlock <= honor;
      if (honor) begin
        jumpAddr <= pk.addr;
      end
      operandRestrict <= seq_next == SEQ_RUN;
    end
  end
endmodule
`default_nettype wire

//--- test/interrupt_vectoring_sva.sv
/*
  checker on the top ports of the interrupt vectoring block.
  assumes it is bound into interrupt_vectoring, one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "interrupt_defines.svh"
module interrupt_vectoring_sva (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic opValid,
  input wire logic [5:0] opMajor,
  input wire logic [5:0] opMinor,
  input wire logic [15:0] extRequest,
  input wire logic instrDone,
  input wire logic [15:0] extRequestAccept,
  input wire logic jumpValid,
  input wire logic [14:0] jumpAddr,
  input wire logic pcTransferBlock,
  input wire logic operandRestrict,
  input wire logic allLockout,
  input wire logic extLockout
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic grp;
  assign grp = opValid && opMajor == `OP_GROUP;
  chk_pc_block: assert property (pcTransferBlock == jumpValid)
    else $error("pc block apart from jump");
  chk_honor_locks: assert property (jumpValid |-> allLockout)
    else $error("honor left lockout clear");
  chk_lock_fault: assert property (
    jumpValid && $past(allLockout) |-> jumpAddr inside {`VEC_FAULT, `VEC_FAULT_RECOV})
    else $error("non fault honored under lockout");
  chk_restrict_end: assert property ($fell(operandRestrict) |-> $past(instrDone))
    else $error("restriction ended early");
  chk_accept_cause: assert property (
    |extRequestAccept |-> !$past(extLockout) && (extRequestAccept & ~$past(extRequest)) == 0)
    else $error("accept without request");
  chk_release_op: assert property (
    $fell(allLockout) |-> $past(grp && opMinor == `SUB_REL_ALL))
    else $error("lockout dropped alone");
  chk_lock_rise: assert property (
    $rose(allLockout) |-> jumpValid || $past(grp && opMinor == `SUB_SET_ALL))
    else $error("lockout rose alone");
  chk_ext_ops: assert property (
    $changed(extLockout) |->
      $past(grp) && $past(opMinor) == (extLockout ? `SUB_SET_OUT : `SUB_REL_OUT))
    else $error("external lockout moved alone");
  chk_jump_hold: assert property (!jumpValid |-> $stable(jumpAddr))
    else $error("jump address moved");
endmodule
bind interrupt_vectoring interrupt_vectoring_sva chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .opValid(opValid), .opMajor(opMajor), .opMinor(opMinor), .extRequest(extRequest),
  .instrDone(instrDone), .extRequestAccept(extRequestAccept), .jumpValid(jumpValid),
  .jumpAddr(jumpAddr), .pcTransferBlock(pcTransferBlock),
  .operandRestrict(operandRestrict), .allLockout(allLockout), .extLockout(extLockout));
`default_nettype wire

//--- test/proc_model.sv
/*
  processor model: fetch strobes while asked, interrupt instruction done
  two or seven cycles after a jump. assumes a synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module proc_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic fetchReq,
  input wire logic slowDone,
  input wire logic jumpValid,
  output logic fetchStart,
  output logic instrDone
);
  logic [2:0] fetchCnt;
  logic [2:0] doneCnt;
  // a fetch every fourth cycle, done counted from the jump
  always_ff @(posedge clk_sys) begin
    fetchCnt <= (sys_rst || !fetchReq) ? 3'h0 : fetchCnt + 3'h1;
    fetchStart <= !sys_rst && fetchReq && fetchCnt[1:0] == 2'h3;
    instrDone <= !sys_rst && doneCnt == 3'h1;
    if (sys_rst) begin
      doneCnt <= 3'h0;
    end else if (jumpValid) begin
      doneCnt <= slowDone ? 3'h6 : 3'h1;
    end else if (doneCnt != 3'h0) begin
      doneCnt <= doneCnt - 3'h1;
    end
  end
endmodule
`default_nettype wire

//--- test/priority_interrupt_vectoring_tb_top.sv
/*
  self-checking bench of the interrupt vectoring block.
  assumes the bound checker and the processor model beside it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "interrupt_defines.svh"
module priority_interrupt_vectoring_tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic opValid = 1'b0, rtcUpdate = 1'b0, resumeFault = 1'b0, extSync = 1'b0;
  logic fetchReq = 1'b0, slowDone = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [5:0] opMajor = 6'h00, opMinor = 6'h00;
  logic [17:0] rtcCountOld = 18'h0, rtcCountNew = 18'h0;
  logic [15:0] extRequest = 16'h0, monitorRequested = 16'h0;
  logic [15:0] fnBufTerm = 16'h0, outBufTerm = 16'h0, inBufTerm = 16'h0;
  logic awready, wready, bvalid, arready, rvalid, jumpValid, pcTransferBlock;
  logic operandRestrict, allLockout, extLockout, fetchStart, instrDone;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata, rd;
  logic [15:0] extRequestAccept, acc;
  logic [14:0] jumpAddr;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  interrupt_vectoring dut (.clk_sys, .sys_rst, .clkEn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .opValid, .opMajor, .opMinor, .rtcUpdate, .rtcCountOld,
    .rtcCountNew, .resumeFault, .extSync, .extRequest, .monitorRequested, .fnBufTerm,
    .outBufTerm, .inBufTerm, .fetchStart, .instrDone, .extRequestAccept, .jumpValid,
    .jumpAddr, .pcTransferBlock, .operandRestrict, .allLockout, .extLockout);
  proc_model cpu (.clk_sys, .sys_rst, .fetchReq, .slowDone, .jumpValid, .fetchStart,
    .instrDone);
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tick(1);
    while (awvalid || wvalid) begin
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      tick(1);
    end
    while (!bvalid) tick(1);
    bready <= 1'b0;
    check("bresp", bresp, resp);
    tick(1);
  endtask
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do tick(1); while (!arready);
    arvalid <= 1'b0;
    do tick(1); while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rr = rresp;
    tick(1);
  endtask
  task automatic op(input logic [5:0] maj, input logic [5:0] mnr);
    opMajor <= maj;
    opMinor <= mnr;
    opValid <= 1'b1;
    tick(1);
    opValid <= 1'b0;
    tick(1);
  endtask
  // the program hands lockout back after each non-fault honor
  task automatic rel();
    op(`OP_GROUP, `SUB_REL_ALL);
  endtask
  task automatic rtc(input logic [17:0] o, input logic [17:0] n);
    rtcCountOld <= o;
    rtcCountNew <= n;
    rtcUpdate <= 1'b1;
    tick(1);
    rtcUpdate <= 1'b0;
    tick(1);
  endtask
  task automatic req(input logic [15:0] m);
    extRequest <= m;
    tick(1);
    extRequest <= 16'h0;
    tick(1);
    acc = extRequestAccept;
  endtask
  task automatic honor(input logic hit, input logic [14:0] exp);
    logic seen;
    seen = 1'b0;
    fetchReq <= 1'b1;
    repeat (16) begin
      tick(1);
      seen = seen | jumpValid;
      if (jumpValid) begin
        check("jumpAddr", jumpAddr, exp);
        check("pcBlock", pcTransferBlock, 1'b1);
        check("lockSet", allLockout, 1'b1);
        check("restrict", operandRestrict, 1'b1);
      end
    end
    fetchReq <= 1'b0;
    check("honored", seen, hit);
    tick(2);
    check("restrictEnd", operandRestrict, 1'b0);
  endtask
  task automatic t_fault();
    logic [5:0] bad [3] = '{`OP_BAD0, `OP_BAD1, `OP_BAD77};
    op(`OP_GROUP, `SUB_SET_ALL);
    foreach (bad[i]) begin
      op(bad[i], 6'h00);
      honor(1'b1, `VEC_FAULT);
    end
    axw(`OFF_CTRL, 32'h1, `RESP_OKAY);
    op(`OP_BAD77, 6'h00);
    honor(1'b1, `VEC_FAULT_RECOV);
    axw(`OFF_CTRL, 32'h0, `RESP_OKAY);
    rel();
    check("released", allLockout, 1'b0);
    honor(1'b0, 15'h0);
    $display("test fault done");
  endtask
  task automatic t_special();
    logic [14:0] v [4] = '{`VEC_RESUME, `VEC_CMP, `VEC_OVF, `VEC_SYNC};
    op(`OP_GROUP, `SUB_SET_ALL);
    extSync <= 1'b1;
    tick(1);
    extSync <= 1'b0;
    honor(1'b0, 15'h0);
    rel();
    honor(1'b1, `VEC_SYNC);
    rel();
    axw(`OFF_CMP, 32'h123, `RESP_OKAY);
    op(`OP_GROUP, `SUB_CMP_ARM);
    rtc(18'h00122, 18'h00123);
    rtc(18'h3ffff, 18'h00000);
    resumeFault <= 1'b1;
    extSync <= 1'b1;
    tick(1);
    resumeFault <= 1'b0;
    extSync <= 1'b0;
    foreach (v[i]) begin
      honor(1'b1, v[i]);
      rel();
    end
    rtc(18'h00122, 18'h00123);
    honor(1'b0, 15'h0);
    $display("test special done");
  endtask
  task automatic t_monitor();
    slowDone <= 1'b1;
    fnBufTerm <= 16'h0200;
    tick(1);
    fnBufTerm <= 16'h0;
    honor(1'b0, 15'h0);
    monitorRequested <= 16'hffff;
    fnBufTerm <= 16'h0200;
    tick(1);
    fnBufTerm <= 16'h0;
    honor(1'b1, 15'h00d2);
    rel();
    outBufTerm <= 16'h0020;
    inBufTerm <= 16'h1000;
    tick(1);
    outBufTerm <= 16'h0002;
    inBufTerm <= 16'h0;
    tick(1);
    outBufTerm <= 16'h0;
    honor(1'b1, 15'h0062);
    rel();
    honor(1'b1, 15'h00f8);
    rel();
    honor(1'b1, 15'h006a);
    rel();
    slowDone <= 1'b0;
    $display("test monitor done");
  endtask
  task automatic t_ext();
    op(`OP_GROUP, `SUB_SET_OUT);
    check("extLock", extLockout, 1'b1);
    req(16'h0008);
    check("lockedAcc", acc, 16'h0);
    op(`OP_GROUP, `SUB_REL_OUT);
    req(16'h0008);
    check("acc", acc, 16'h0008);
    req(16'h0008);
    check("heldAcc", acc, 16'h0);
    honor(1'b1, 15'h0046);
    axr(`OFF_EIMON);
    check("monKept", rd, 32'h8);
    rel();
    axr(`OFF_EIMON);
    check("monFreed", rd, 32'h0);
    req(16'h0800);
    honor(1'b1, 15'h00c6);
    rel();
    $display("test external done");
  endtask
  initial begin
    tick(4);
    sys_rst <= 1'b0;
    tick(1);
    check("idleReady", {awready, wready, arready}, 3'h7);
    check("jumpRst", jumpAddr, 15'h0);
    axr(8'h40);
    check("badRead", rr, `RESP_SLVERR);
    axw(8'h40, 32'h1, `RESP_SLVERR);
    axw(`OFF_STATUS, 32'hffffffff, `RESP_OKAY);
    axr(`OFF_STATUS);
    check("statusRo", rd, 32'h0);
    // an event while the clock enable is low must leave no trace
    clkEn <= 1'b0;
    extSync <= 1'b1;
    tick(1);
    clkEn <= 1'b1;
    extSync <= 1'b0;
    axr(`OFF_STATUS);
    check("frozen", rd, 32'h0);
    $display("test registers done");
    t_fault();
    t_special();
    t_monitor();
    t_ext();
    stop_test();
  end
endmodule
`default_nettype wire
